// ### ssl_step_limits.sv
/*
 * Step delay and loop counter limit registers with their step timer and
 * counter 0, behind an AXI4-Lite slave.
 * Assumes the sequencer issues one-cycle command pulses synchronous to clk.
 */
`timescale 1ns/1ns

// Contract
// R1: The step delay limit counts extra clocks between a step command start and its end.
// R2: One base clock is always added, so a step lasts the stored limit plus one clocks.
// R3: While enable and start are both 1, writes to both limit registers are ignored.
// R4: The loop counter 0 limit is the loop count of the jump-on-counter-0 command.
// R5: The same limit also serves as terminal value of counter 0 used as a plain counter.
// R6: Limit writes made while idle take effect on the next step or counted loop.
module ssl_step_limits
(
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        reset,
   // AXI4-Lite write address and data
   input  wire logic                        awvalid,
   output logic                             awready,
   input  wire logic [ssl_pkg::ADDR_W-1:0]  awaddr,
   input  wire logic                        wvalid,
   output logic                             wready,
   input  wire logic [ssl_pkg::DATA_W-1:0]  wdata,
   input  wire logic [3:0]                  wstrb,
   // AXI4-Lite write response
   output logic                             bvalid,
   input  wire logic                        bready,
   output logic [1:0]                       bresp,
   // AXI4-Lite read
   input  wire logic                        arvalid,
   output logic                             arready,
   input  wire logic [ssl_pkg::ADDR_W-1:0]  araddr,
   output logic                             rvalid,
   input  wire logic                        rready,
   output logic [ssl_pkg::DATA_W-1:0]       rdata,
   output logic [1:0]                       rresp,
   // Sequencer commands and results
   input  wire ssl_pkg::ssl_cmd_t           cmd,
   output ssl_pkg::ssl_res_t                res
);

   ssl_pkg::ssl_state_t st;
   ssl_pkg::ssl_state_t next_st;
   logic                running;
   logic                wrFire;
   logic                rdFire;

   // Locked while the sequencer executes steps
   assign running = st.enable && st.start;
   // Both write channels are taken together; keeps one response per pair
   assign awready = awvalid && wvalid && !st.bvalid;
   assign wready  = awready;
   assign wrFire  = awready;
   assign arready = !st.rvalid;
   assign rdFire  = arvalid && arready;

   assign bvalid = st.bvalid;
   assign bresp  = st.bresp;
   assign rvalid = st.rvalid;
   assign rdata  = st.rdata;
   assign rresp  = st.rresp;
   assign res    = st.res;

   // Next-state logic for bus, registers, step timer and counter 0
   always_comb
   begin
      next_st = st;
      next_st.res.stepDone = 1'b0;
      next_st.res.jumpDone = 1'b0;

      // Write channel
      if (st.bvalid && bready)
      begin
         next_st.bvalid = 1'b0;
      end
      if (wrFire)
      begin
         next_st.bvalid = 1'b1;
         next_st.bresp  = ssl_pkg::RESP_OKAY;
         case (awaddr)
            ssl_pkg::OFS_STEP_LIM:
            begin
               if (!running) // R3
               begin
                  if (wstrb[0]) next_st.stepLimit[7:0]  = wdata[7:0];
                  if (wstrb[1]) next_st.stepLimit[15:8] = wdata[15:8];
               end
            end
            ssl_pkg::OFS_LOOP_LIM:
            begin
               if (!running) // R3
               begin
                  if (wstrb[0]) next_st.loopLimit[7:0]  = wdata[7:0];
                  if (wstrb[1]) next_st.loopLimit[15:8] = wdata[15:8];
               end
            end
            ssl_pkg::OFS_CONTROL:
            begin
               if (wstrb[0])
               begin
                  next_st.enable = wdata[ssl_pkg::BIT_ENABLE];
                  next_st.start  = wdata[ssl_pkg::BIT_START];
               end
            end
            ssl_pkg::OFS_STATUS:
            begin
               next_st.bresp = ssl_pkg::RESP_OKAY; // Read-only, write dropped
            end
            default:
            begin
               next_st.bresp = ssl_pkg::RESP_SLVERR;
            end
         endcase
      end

      // Read channel
      if (st.rvalid && rready)
      begin
         next_st.rvalid = 1'b0;
      end
      if (rdFire)
      begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = ssl_pkg::RESP_OKAY;
         next_st.rdata  = '0;
         case (araddr)
            ssl_pkg::OFS_STEP_LIM: next_st.rdata[15:0] = st.stepLimit;
            ssl_pkg::OFS_LOOP_LIM: next_st.rdata[15:0] = st.loopLimit;
            ssl_pkg::OFS_CONTROL:
            begin
               next_st.rdata[ssl_pkg::BIT_ENABLE] = st.enable;
               next_st.rdata[ssl_pkg::BIT_START]  = st.start;
            end
            ssl_pkg::OFS_STATUS:
            begin
               next_st.rdata[ssl_pkg::BIT_BUSY]    = (st.stepState == ssl_pkg::SSL_DELAY);
               next_st.rdata[ssl_pkg::BIT_ATLIMIT] = st.res.cnt0AtLimit;
               next_st.rdata[ssl_pkg::BIT_RUNNING] = running;
               next_st.rdata[ssl_pkg::CNT_LSB +: ssl_pkg::LIM_W] = st.cnt0;
            end
            default:
            begin
               next_st.rresp = ssl_pkg::RESP_SLVERR;
            end
         endcase
      end

      // Step timer: limit sampled at command start, so idle writes count next time
      case (st.stepState)
         ssl_pkg::SSL_IDLE:
         begin
            if (running && cmd.stepCmd)
            begin
               next_st.stepCount = st.stepLimit; // R1 R6
               next_st.stepState = ssl_pkg::SSL_DELAY;
            end
         end
         ssl_pkg::SSL_DELAY:
         begin
            if (!running)
            begin
               next_st.stepState = ssl_pkg::SSL_IDLE; // Abort drops the step silently
            end
            else if (st.stepCount == ssl_pkg::LIM_RESET)
            begin
               next_st.res.stepDone = 1'b1; // R2
               next_st.stepState    = ssl_pkg::SSL_IDLE;
            end
            else
            begin
               next_st.stepCount = st.stepCount - ssl_pkg::CNT_ONE; // R1
            end
         end
         default:
         begin
            next_st.stepState = ssl_pkg::SSL_IDLE;
         end
      endcase

      // Counter 0: jump loop count or free counter with terminal limit
      if (!st.enable)
      begin
         next_st.cnt0 = ssl_pkg::LIM_RESET;
      end
      else if (running && cmd.jumpCmd)
      begin
         next_st.res.jumpDone = 1'b1;
         if (st.cnt0 == st.loopLimit) // R4
         begin
            next_st.cnt0          = ssl_pkg::LIM_RESET; // R6
            next_st.res.jumpTaken = 1'b0;
         end
         else
         begin
            next_st.cnt0          = st.cnt0 + ssl_pkg::CNT_ONE;
            next_st.res.jumpTaken = 1'b1;
         end
      end
      else if (cmd.cnt0Inc && st.cnt0 != st.loopLimit)
      begin
         next_st.cnt0 = st.cnt0 + ssl_pkg::CNT_ONE; // R5
      end
      next_st.res.cnt0AtLimit = (next_st.cnt0 == st.loopLimit); // R5
      next_st.res.running     = next_st.enable && next_st.start;
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Assertions
   property p_step_len;
      @(posedge clk) disable iff (reset)
      (st.stepState == ssl_pkg::SSL_IDLE && running && cmd.stepCmd && st.stepLimit == 16'h0002)
         ##1 running [*3] |=> res.stepDone;
   endproperty
   a_step_len: assert property (p_step_len) else $error("step length wrong"); // R1

   property p_base_clock;
      @(posedge clk) disable iff (reset)
      (st.stepState == ssl_pkg::SSL_IDLE && running && cmd.stepCmd && st.stepLimit == 16'h0000)
         ##1 running |=> res.stepDone;
   endproperty
   a_base_clock: assert property (p_base_clock) else $error("base step clock missing"); // R2

   property p_lock;
      @(posedge clk) disable iff (reset)
      running |=> (st.stepLimit == $past(st.stepLimit) && st.loopLimit == $past(st.loopLimit));
   endproperty
   a_lock: assert property (p_lock) else $error("limit changed while running"); // R3

   property p_jump;
      @(posedge clk) disable iff (reset)
      (running && cmd.jumpCmd) |=> (res.jumpDone && res.jumpTaken == ($past(st.cnt0) != $past(st.loopLimit)));
   endproperty
   a_jump: assert property (p_jump) else $error("jump decision wrong"); // R4

   // Flag is registered with the counter against last cycle's limit; reset clears it, so the cycle after release is skipped
   property p_limit_flag;
      @(posedge clk) disable iff (reset)
      1'b1 ##1 !$past(reset) |-> (res.cnt0AtLimit == (st.cnt0 == $past(st.loopLimit)));
   endproperty
   a_limit_flag: assert property (p_limit_flag) else $error("counter limit flag wrong"); // R5

   property p_idle_write;
      @(posedge clk) disable iff (reset)
      (!running && wrFire && awaddr == ssl_pkg::OFS_STEP_LIM && wstrb == 4'hF)
         |=> st.stepLimit == $past(wdata[15:0]);
   endproperty
   a_idle_write: assert property (p_idle_write) else $error("idle limit write lost"); // R6

   c_step:  cover property (@(posedge clk) disable iff (reset) res.stepDone);
   c_taken: cover property (@(posedge clk) disable iff (reset) res.jumpDone && res.jumpTaken);
   c_exit:  cover property (@(posedge clk) disable iff (reset) res.jumpDone && !res.jumpTaken);
endmodule

// ### ssl_pkg.sv
/*
 * Shared constants and types for the step sequencer limit registers.
 * Assumes a 32-bit AXI4-Lite register bus and a single 50 MHz clock.
 */
package ssl_pkg;
   // Limit width and bus geometry
   localparam int          LIM_W        = 16;
   localparam int          ADDR_W       = 4;
   localparam int          DATA_W       = 32;
   // Register byte offsets
   localparam logic [3:0]  OFS_STEP_LIM = 4'h0;
   localparam logic [3:0]  OFS_LOOP_LIM = 4'h4;
   localparam logic [3:0]  OFS_CONTROL  = 4'h8;
   localparam logic [3:0]  OFS_STATUS   = 4'hC;
   // Control and status bit positions
   localparam int          BIT_ENABLE   = 0;
   localparam int          BIT_START    = 1;
   localparam int          BIT_BUSY     = 0;
   localparam int          BIT_ATLIMIT  = 1;
   localparam int          BIT_RUNNING  = 2;
   localparam int          CNT_LSB      = 16;
   // Reset values and constants
   localparam logic [15:0] LIM_RESET    = 16'h0000;
   localparam logic [15:0] CNT_ONE      = 16'h0001;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   typedef enum logic {SSL_IDLE, SSL_DELAY} ssl_step_t;

   // Sequencer-side command and result groups
   typedef struct packed {
      logic stepCmd;
      logic jumpCmd;
      logic cnt0Inc;
   } ssl_cmd_t;

   typedef struct packed {
      logic stepDone;
      logic jumpDone;
      logic jumpTaken;
      logic cnt0AtLimit;
      logic running;
   } ssl_res_t;

   // Whole module state
   typedef struct packed {
      ssl_step_t         stepState;
      logic [LIM_W-1:0]  stepCount;
      logic [LIM_W-1:0]  stepLimit;
      logic [LIM_W-1:0]  loopLimit;
      logic [LIM_W-1:0]  cnt0;
      logic              enable;
      logic              start;
      ssl_res_t          res;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [DATA_W-1:0] rdata;
   } ssl_state_t;
endpackage

// ### ssl_tb.sv
/*
 * Self-checking bench for the step sequencer limit registers.
 * Assumes the design answers AXI4-Lite requests one cycle after taking them.
 */
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("Error %s expected %0h seen %0h", nm, ex, got); end end

module tb;
   // Clock, reset and bus
   logic                           clk = 1'b0;
   logic                           reset = 1'b1;
   logic                           awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic                           arvalid = 1'b0, rready = 1'b0;
   logic                           awready, wready, bvalid, arready, rvalid;
   logic [3:0]                     awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0]                    wdata = 32'h0, rdata, rd;
   logic [1:0]                     bresp, rresp, rr, wrsp;
   ssl_pkg::ssl_cmd_t              cmd = '0;
   ssl_pkg::ssl_res_t              res;
   int                             n_mismatch = 0, checked = 0, lim;

   always #10 clk = ~clk;

   ssl_step_limits dut (.clk(clk), .reset(reset), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .cmd(cmd), .res(res));

   // Verdict and end of run
   task stop_test;
      $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Bounded wait on a flag sampled at the edge
   task automatic wait_hi(ref logic sig);
      int k;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (sig !== 1'b1 && k < 50);
      if (sig !== 1'b1)
      begin
         n_mismatch++;
         $display("Error handshake expected 1 seen %0b", sig);
         stop_test();
      end
   endtask

   // Write: address and data offered together, response awaited
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hF;
      wait_hi(awready);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      bready  <= 1'b1;
      wait_hi(bvalid);
      wrsp    = bresp;
      bready  <= 1'b0;
   endtask

   // Read: data and response taken at the rvalid edge
   task rdw(input logic [3:0] a);
      @(posedge clk);
      arvalid <= 1'b1;
      araddr  <= a;
      wait_hi(arready);
      arvalid <= 1'b0;
      rready  <= 1'b1;
      wait_hi(rvalid);
      rd = rdata;
      rr = rresp;
      rready  <= 1'b0;
   endtask

   // One pulse on a command line, driven just after an edge
   task pulse(input int which);
      @(posedge clk);
      cmd <= ssl_pkg::ssl_cmd_t'(3'h1 << which);
      @(posedge clk);
      cmd <= '0;
   endtask

   // Main sequence
   initial
   begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      rdw(ssl_pkg::OFS_STEP_LIM);
      `CHK("stepLimitReset", 32'h0, rd)
      `CHK("readResp", ssl_pkg::RESP_OKAY, rr)
      wr(4'h2, 32'h0);
      `CHK("unmappedWrResp", ssl_pkg::RESP_SLVERR, wrsp)
      rdw(ssl_pkg::OFS_LOOP_LIM);
      `CHK("loopLimitReset", 32'h0, rd)
      rdw(4'h2);
      `CHK("unmappedResp", ssl_pkg::RESP_SLVERR, rr)
      // Boundary limit 0, then 2, written while stopped
      for (int i = 0; i < 2; i++)
      begin
         lim = i * 2;
         wr(ssl_pkg::OFS_CONTROL, 32'h0);
         wr(ssl_pkg::OFS_STEP_LIM, 32'(lim));
         wr(ssl_pkg::OFS_CONTROL, 32'h3);
         pulse(2);
         for (int k = 2; k < 40 && res.stepDone !== 1'b1; k++)
         begin
            @(posedge clk);
            `CHK("stepLength", lim + 3, (res.stepDone === 1'b1) ? k : lim + 3)
         end
         `CHK("stepDoneSeen", 1'b1, res.stepDone)
      end
      // Locked while enabled and started
      wr(ssl_pkg::OFS_STEP_LIM, 32'h5);
      wr(ssl_pkg::OFS_LOOP_LIM, 32'h7);
      `CHK("lockedResp", ssl_pkg::RESP_OKAY, wrsp)
      rdw(ssl_pkg::OFS_STEP_LIM);
      `CHK("stepLimitLocked", 32'h2, rd)
      rdw(ssl_pkg::OFS_LOOP_LIM);
      `CHK("loopLimitLocked", 32'h0, rd)
      // Loop count of two: taken twice, then fall through
      wr(ssl_pkg::OFS_CONTROL, 32'h0);
      wr(ssl_pkg::OFS_LOOP_LIM, 32'h2);
      wr(ssl_pkg::OFS_CONTROL, 32'h3);
      `CHK("running", 1'b1, res.running)
      for (int j = 0; j < 3; j++)
      begin
         pulse(1);
         @(posedge clk);
         `CHK("jumpDone", 1'b1, res.jumpDone)
         `CHK("jumpTaken", (j < 2), res.jumpTaken)
      end
      // Plain counter saturates at the limit
      repeat (3) pulse(0);
      @(posedge clk);
      `CHK("atLimit", 1'b1, res.cnt0AtLimit)
      rdw(ssl_pkg::OFS_STATUS);
      `CHK("cnt0Value", 16'h2, rd[31:16])
      stop_test();
   end
endmodule
